// file: timer8_defines.svh
// timer8_defines.svh: register offsets, field positions, reset values and counts
// assumes inclusion by the compare unit module, checker and testbench
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_CONTROL 12'h000
`define ADDR_COUNTER 12'h004
`define ADDR_COMPARE 12'h008
`define ADDR_FLAGS 12'h00C
`define ADDR_IRQ_ENABLE 12'h010

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_WGM_LSB 0
`define CTRL_COM_LSB 2
`define CTRL_CS_LSB 4
`define CTRL_FORCE_BIT 7

// flags and enables share bit positions
`define FLAG_OVF_BIT 0
`define FLAG_CMP_BIT 1

// ----------------------------------------
// reset values and counter limits
// ----------------------------------------
`define RESET_BYTE 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00

// prescaler counter width in bits, enough for the longest tap of 1024 ref_clk cycles
`define PRESCALE_BITS 10

`endif

// file: timer8_output_compare_unit.sv
// timer8_output_compare_unit.sv: 8-bit timer counter, compare unit and pin override
// assumes an APB master on ref_clk and an external port driver for the pin
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "timer8_defines.svh"

module timer8_output_compare_unit
    import timer8_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    input wire logic port_data_bit,
    input wire logic output_pin_direction_bit,
    output logic compare_irq,
    output logic overflow_irq,
    output logic pin_out,
    output logic pin_oe
);

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire bus_access = psel && penable;
    wire bus_write = bus_access && pwrite;
    wire hit_control = paddr == `ADDR_CONTROL;
    wire hit_counter = paddr == `ADDR_COUNTER;
    wire hit_compare = paddr == `ADDR_COMPARE;
    wire hit_flags = paddr == `ADDR_FLAGS;
    wire hit_enable = paddr == `ADDR_IRQ_ENABLE;
    wire hit_any = hit_control || hit_counter || hit_compare || hit_flags || hit_enable;
    wire wr_control = bus_write && hit_control;
    wire wr_counter = bus_write && hit_counter;
    wire wr_compare = bus_write && hit_compare;
    wire wr_flags = bus_write && hit_flags;
    wire wr_enable = bus_write && hit_enable;

    assign pready = 1'b1;
    assign pslverr = bus_access && !hit_any;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    wave_mode_t waveform_select;
    out_action_t output_action_select;
    logic [2:0] clock_source_select;
    logic [7:0] counter_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic compare_match_flag;
    logic overflow_flag;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic waveform_output;
    logic count_down;
    logic block_match;
    logic [`PRESCALE_BITS-1:0] prescale;

    wire pwm_mode = waveform_select == mode_pwm_fast || waveform_select == mode_pwm_phase;
    wire force_compare_strobe = wr_control && pwdata[`CTRL_FORCE_BIT] && !pwm_mode;

    // ----------------------------------------
    // timer tick from prescaler
    // ----------------------------------------
    // taps 1, 8, 32, 64, 128, 256, 1024 cycles; source zero stops the timer
    logic tick_sel;
    always_comb begin
        case (clock_source_select)
            3'd1: tick_sel = 1'b1;
            3'd2: tick_sel = &prescale[2:0];
            3'd3: tick_sel = &prescale[4:0];
            3'd4: tick_sel = &prescale[5:0];
            3'd5: tick_sel = &prescale[6:0];
            3'd6: tick_sel = &prescale[7:0];
            3'd7: tick_sel = &prescale[9:0];
            default: tick_sel = 1'b0;
        endcase
    end
    wire tick = tick_sel;

    always_ff @(posedge ref_clk) begin
        if (!rst_n || clock_source_select == 3'd0) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // ----------------------------------------
    // compare and counter sequencing
    // ----------------------------------------
    wire raw_match = counter_value == compare_value;
    wire match = raw_match && !block_match;
    wire at_max = counter_value == `COUNT_MAX;
    wire at_bottom = counter_value == `COUNT_BOTTOM;
    // ctc clears on match, otherwise wraps naturally
    wire ctc_clear = waveform_select == mode_ctc && match;

    logic [7:0] next_counter;
    logic next_down;
    always_comb begin
        next_counter = counter_value;
        next_down = count_down;
        case (waveform_select)
            mode_normal: next_counter = counter_value + 8'h01;
            mode_ctc: next_counter = ctc_clear ? `COUNT_BOTTOM : counter_value + 8'h01;
            mode_pwm_fast: next_counter = counter_value + 8'h01;
            mode_pwm_phase: begin
                if (at_max) begin
                    next_down = 1'b1;
                end else if (at_bottom) begin
                    next_down = 1'b0;
                end
                next_counter = next_down ? counter_value - 8'h01 : counter_value + 8'h01;
            end
            default: next_counter = counter_value;
        endcase
    end

    // overflow when stepping from max to zero, or at bottom in phase-correct
    wire overflow_event = tick && !wr_counter && (waveform_select == mode_pwm_phase ?
        (at_bottom && count_down) : (next_counter == `COUNT_BOTTOM && at_max));
    // top for fast pwm is max, bottom for phase-correct
    wire buffer_load = pwm_mode && tick && (waveform_select == mode_pwm_fast ? at_max :
        at_bottom);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            counter_value <= `RESET_BYTE;
            count_down <= 1'b0;
        end else if (wr_counter) begin
            counter_value <= pwdata[7:0];
        end else if (tick) begin
            counter_value <= next_counter;
            count_down <= next_down;
        end
    end

    // the block lasts until the tick that follows the write
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            block_match <= 1'b0;
        end else if (wr_counter) begin
            block_match <= 1'b1;
        end else if (tick) begin
            block_match <= 1'b0;
        end
    end

    // ----------------------------------------
    // compare register and buffer
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            compare_value <= `RESET_BYTE;
            compare_buffer <= `RESET_BYTE;
        end else begin
            if (wr_compare) begin
                compare_buffer <= pwdata[7:0];
            end
            if (wr_compare && !pwm_mode) begin
                compare_value <= pwdata[7:0];
            end else if (buffer_load) begin
                compare_value <= compare_buffer;
            end
        end
    end

    // ----------------------------------------
    // flags and interrupt requests
    // ----------------------------------------
    wire cmp_set = tick && match;
    wire cmp_clr = (wr_flags && pwdata[`FLAG_CMP_BIT]) || compare_irq_ack;
    wire ovf_clr = (wr_flags && pwdata[`FLAG_OVF_BIT]) || overflow_irq_ack;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            compare_match_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            // a set in the clearing cycle wins
            compare_match_flag <= cmp_set || (compare_match_flag && !cmp_clr);
            overflow_flag <= overflow_event || (overflow_flag && !ovf_clr);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            compare_irq_enable <= 1'b0;
            overflow_irq_enable <= 1'b0;
        end else if (wr_enable) begin
            compare_irq_enable <= pwdata[`FLAG_CMP_BIT];
            overflow_irq_enable <= pwdata[`FLAG_OVF_BIT];
        end
    end

    assign compare_irq = compare_match_flag && compare_irq_enable;
    assign overflow_irq = overflow_flag && overflow_irq_enable;

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            waveform_select <= mode_normal;
            output_action_select <= act_none;
            clock_source_select <= 3'd0;
        end else if (wr_control) begin
            waveform_select <= wave_mode_t'(pwdata[`CTRL_WGM_LSB +: 2]);
            output_action_select <= out_action_t'(pwdata[`CTRL_COM_LSB +: 2]);
            clock_source_select <= pwdata[`CTRL_CS_LSB +: 3];
        end
    end

    // ----------------------------------------
    // waveform generator
    // ----------------------------------------
    // pwm: act_clear is non-inverted, act_set inverted; toggle only in fast pwm
    wire pwm_level_at_match = (output_action_select == act_set);
    logic next_wave;
    always_comb begin
        next_wave = waveform_output;
        if (!pwm_mode && ((tick && match) || force_compare_strobe)) begin
            case (output_action_select)
                act_toggle: next_wave = !waveform_output;
                act_clear: next_wave = 1'b0;
                act_set: next_wave = 1'b1;
                default: next_wave = waveform_output;
            endcase
        end else if (pwm_mode && tick && output_action_select != act_none) begin
            if (output_action_select == act_toggle) begin
                if (waveform_select == mode_pwm_fast && match) begin
                    next_wave = !waveform_output;
                end
            end else if (waveform_select == mode_pwm_fast) begin
                if (match) begin
                    next_wave = pwm_level_at_match;
                end else if (at_max) begin
                    next_wave = !pwm_level_at_match;
                end
            end else if (match) begin
                // phase-correct: up-count match uses the polarity level
                next_wave = count_down ? !pwm_level_at_match : pwm_level_at_match;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            waveform_output <= 1'b0;
        end else begin
            waveform_output <= next_wave;
        end
    end

    // ----------------------------------------
    // pin override
    // ----------------------------------------
    wire override = output_action_select != act_none;
    assign pin_out = override ? waveform_output : port_data_bit;
    assign pin_oe = output_pin_direction_bit;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_control) begin
            next_rdata[7:0] = {1'b0, clock_source_select, output_action_select,
                waveform_select};
        end else if (hit_counter) begin
            next_rdata[7:0] = counter_value;
        end else if (hit_compare) begin
            next_rdata[7:0] = pwm_mode ? compare_buffer : compare_value;
        end else if (hit_flags) begin
            next_rdata[1:0] = {compare_match_flag, overflow_flag};
        end else if (hit_enable) begin
            next_rdata[1:0] = {compare_irq_enable, overflow_irq_enable};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_rdata;
        end
    end

endmodule : timer8_output_compare_unit

// file: timer8_output_compare_unit_properties.sv
// port-level checks of the timer compare unit
// assumes binding to timer8_output_compare_unit by the statement at the foot
`timescale 1ns/10ps
`include "timer8_defines.svh"

module timer8_ocu_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    input wire logic port_data_bit,
    input wire logic output_pin_direction_bit,
    input wire logic compare_irq,
    input wire logic overflow_irq,
    input wire logic pin_out,
    input wire logic pin_oe
);
    // ----------------------------------------
    // shadow of software settings
    // ----------------------------------------
    logic [1:0] act;
    logic [1:0] ena;
    logic [2:0] src;
    wire wr = psel && penable && pwrite;
    wire wr_flg = wr && paddr == `ADDR_FLAGS;
    wire wr_en = wr && paddr == `ADDR_IRQ_ENABLE;
    wire mapped = paddr[1:0] == 2'h0 && paddr <= `ADDR_IRQ_ENABLE;
    // no tick can set a flag while stopped, so clears are exact then
    wire stopped = src == 3'h0 && !wr;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            act <= 2'h0;
            ena <= 2'h0;
            src <= 3'h0;
        end else begin
            if (wr && paddr == `ADDR_CONTROL) begin
                act <= pwdata[3:2];
                src <= pwdata[6:4];
            end
            if (wr_en) begin
                ena <= pwdata[1:0];
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_pin_dir_follow: assert property (pin_oe == output_pin_direction_bit)
        else $error("pin enable differs from direction bit");
    a_port_passes: assert property (act == 2'h0 |-> pin_out == port_data_bit)
        else $error("pin not from port with action zero");
    a_cmp_irq_gate: assert property (compare_irq |-> ena[1])
        else $error("compare request while disabled");
    a_ovf_irq_gate: assert property (overflow_irq |-> ena[0])
        else $error("overflow request while disabled");
    a_cmp_ack_clears: assert property (compare_irq_ack && stopped |=> !compare_irq)
        else $error("compare flag kept after ack");
    a_ovf_ack_clears: assert property (overflow_irq_ack && stopped |=> !overflow_irq)
        else $error("overflow flag kept after ack");
    a_flag_one_clears: assert property (wr_flg && pwdata[1] && src == 3'h0 |=> !compare_irq)
        else $error("compare flag kept after write of one");
    a_cmp_flag_holds: assert property (compare_irq && !compare_irq_ack && !wr_flg && !wr_en
        |=> compare_irq)
        else $error("compare flag dropped by itself");
    a_ovf_flag_holds: assert property (overflow_irq && !overflow_irq_ack && !wr_flg && !wr_en
        |=> overflow_irq)
        else $error("overflow flag dropped by counting");
    a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
        else $error("slave error disagrees with address map");

    c_force: cover property (wr && paddr == `ADDR_CONTROL && pwdata[7]);
    c_toggle: cover property (compare_irq && act == 2'h1);
    c_ovf_ack: cover property (overflow_irq_ack && overflow_irq);
endmodule : timer8_ocu_checker

bind timer8_output_compare_unit timer8_ocu_checker u_timer8_ocu_checker (.ref_clk, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .compare_irq_ack, .overflow_irq_ack,
    .port_data_bit, .output_pin_direction_bit, .compare_irq, .overflow_irq, .pin_out, .pin_oe);

// file: timer8_output_compare_unit_tb.sv
// self-checking bench of the timer compare unit
// assumes package, header and checker compiled before it
`timescale 1ns/10ps
`include "timer8_defines.svh"

module timer8_output_compare_unit_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic compare_irq_ack = 1'b0;
    logic overflow_irq_ack = 1'b0;
    logic port_data_bit = 1'b0;
    logic output_pin_direction_bit = 1'b0;
    logic compare_irq;
    logic overflow_irq;
    logic pin_out;
    logic pin_oe;
    int errors = 0;
    int n_tests = 0;
    int i;
    int tg;
    logic [31:0] rd;
    logic slv;
    logic wf = 1'b0;
    logic prev;
    logic [3:0] c;
    logic [7:0] r;
    logic [31:0] row;
    // mode, compare before, compare after, counter start
    localparam logic [31:0] ROWS [5] = '{32'h0020_901E, 32'h0320_901E, 32'h0120_901E,
        32'h0040_4040, 32'h0240_4040};

    timer8_output_compare_unit u_timer8_output_compare_unit (.ref_clk, .rst_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .compare_irq_ack,
        .overflow_irq_ack, .port_data_bit, .output_pin_direction_bit, .compare_irq,
        .overflow_irq, .pin_out, .pin_oe);

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // tasks and expectation model
    // ----------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_pin(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_pin

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            errors++;
            close_out();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_irq(input logic cmp, input int lim);
        int k;
        k = 0;
        while ((cmp ? compare_irq : overflow_irq) !== 1'b1 && k < lim) begin
            @(posedge ref_clk);
            k++;
        end
        if ((cmp ? compare_irq : overflow_irq) !== 1'b1) begin
            errors++;
            close_out();
        end
    endtask : wait_irq

    // pwm modes ignore the force strobe
    function automatic logic next_wf(input logic [3:0] cc, input logic w);
        if (cc[0]) begin
            return w;
        end
        case (cc[3:2])
            2'h1: return ~w;
            2'h2: return 1'b0;
            2'h3: return 1'b1;
            default: return w;
        endcase
    endfunction : next_wf

    initial begin
        void'($urandom(32'h1b8f));
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            chk_pin(slv, i == 5);
        end
        $display("test 1 done");
        apb(1'b1, `ADDR_COUNTER, 32'h0000_0005);
        apb(1'b1, `ADDR_COMPARE, 32'h0000_0080);
        for (i = 0; i < 40; i++) begin
            c = (i < 16) ? 4'(i) : 4'($urandom % 16);
            port_data_bit <= 1'($urandom % 2);
            output_pin_direction_bit <= 1'($urandom % 2);
            apb(1'b1, `ADDR_CONTROL, {28'h0, c});
            apb(1'b1, `ADDR_CONTROL, {24'h0, 4'h8, c});
            wf = next_wf(c, wf);
            apb(1'b0, `ADDR_CONTROL, 32'h0000_0000);
            chk(rd, {28'h0, c});
            @(negedge ref_clk);
            chk_pin(pin_out, (c[3:2] != 2'h0) ? wf : port_data_bit);
            chk_pin(pin_oe, output_pin_direction_bit);
        end
        apb(1'b0, `ADDR_COUNTER, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        apb(1'b0, `ADDR_FLAGS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test 2 done");
        for (i = 0; i < 5; i++) begin
            row = ROWS[i];
            apb(1'b1, `ADDR_CONTROL, 32'h0000_0000);
            apb(1'b1, `ADDR_COMPARE, {24'h0, row[23:16]});
            apb(1'b1, `ADDR_CONTROL, {24'h0, row[31:24]});
            apb(1'b1, `ADDR_COMPARE, {24'h0, row[15:8]});
            apb(1'b0, `ADDR_COMPARE, 32'h0000_0000);
            chk(rd, {24'h0, row[15:8]});
            apb(1'b1, `ADDR_COUNTER, {24'h0, row[7:0]});
            apb(1'b1, `ADDR_FLAGS, 32'h0000_0003);
            apb(1'b1, `ADDR_CONTROL, {24'h0, row[31:24] | 8'h10});
            repeat (8) @(posedge ref_clk);
            apb(1'b1, `ADDR_CONTROL, {24'h0, row[31:24]});
            apb(1'b0, `ADDR_FLAGS, 32'h0000_0000);
            chk_pin(rd[1], row[24]);
        end
        $display("test 3 done");
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0000);
        apb(1'b1, `ADDR_IRQ_ENABLE, 32'h0000_0003);
        apb(1'b1, `ADDR_FLAGS, 32'h0000_0003);
        apb(1'b1, `ADDR_COUNTER, 32'h0000_00F8);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0010);
        wait_irq(1'b0, 40);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0000);
        apb(1'b0, `ADDR_COUNTER, 32'h0000_0000);
        chk_pin(rd < 32'h0000_0010, 1'b1);
        repeat (20) @(posedge ref_clk);
        chk_pin(overflow_irq, 1'b1);
        overflow_irq_ack <= 1'b1;
        @(posedge ref_clk);
        overflow_irq_ack <= 1'b0;
        @(negedge ref_clk);
        chk_pin(overflow_irq, 1'b0);
        $display("test 4 done");
        r = 8'(8 + $urandom % 24);
        apb(1'b1, `ADDR_COMPARE, {24'h0, r});
        apb(1'b1, `ADDR_COUNTER, 32'h0000_0000);
        apb(1'b1, `ADDR_FLAGS, 32'h0000_0003);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0016);
        wait_irq(1'b1, 80);
        for (i = 0; i < 12; i++) begin
            apb(1'b0, `ADDR_COUNTER, 32'h0000_0000);
            chk_pin(rd <= {24'h0, r}, 1'b1);
        end
        @(negedge ref_clk);
        prev = pin_out;
        tg = 0;
        for (i = 0; i < 4 * (r + 1); i++) begin
            @(negedge ref_clk);
            tg += (pin_out !== prev) ? 1 : 0;
            prev = pin_out;
        end
        chk(32'(tg), 32'h0000_0004);
        chk_pin(overflow_irq, 1'b0);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0000);
        compare_irq_ack <= 1'b1;
        @(posedge ref_clk);
        compare_irq_ack <= 1'b0;
        @(negedge ref_clk);
        chk_pin(compare_irq, 1'b0);
        $display("test 5 done");
        close_out();
    end
endmodule : timer8_output_compare_unit_tb

// file: timer8_pkg.sv
// timer8_pkg.sv: types of the timer compare unit
// assumes timer8_defines.svh is included beside it
package timer8_pkg;
    typedef enum logic [1:0] {
        mode_normal,
        mode_pwm_phase,
        mode_ctc,
        mode_pwm_fast
    } wave_mode_t;

    typedef enum logic [1:0] {
        act_none,
        act_toggle,
        act_clear,
        act_set
    } out_action_t;
endpackage : timer8_pkg
